/* inc/loop_opt_pkg.sv */
// constants for the two-channel loop detector option block
// assumes a 25 MHz core clock and word-aligned register offsets
//
// Functional notes
// - extension gated by phase green when enabled
// - filter bypass skips noise filter, both channels
// - changing filter bypass resets whole detector
// - green compensation desensitises 0.05% over 15s
// - count display replaces normal channel display
// - vehicle counter rolls over after 65535
// - show low three digits, alternate above 999
// - counter clear rising zeroes count, reads off
// - loop arrangement setting per channel, 7.01-7.05
// - shared fail drives both fail outputs
// - AND pairing calls only when both occupied or extending
// - AND pairing first detector shows pending
// - directional first detector pending, no call
// - directional later channel calls until it clears
// - directional first channel untimed, presence only
// - buzzer follows raw occupancy of selected channel
// - audible on one channel turns other off
// - audible turns off after 15 minutes
// - disconnect: normal when green inactive
// - disconnect timeout suppresses call until green ends
// - disconnect subtype selects extension or occupancy call
// - extension restarts at each clearing of zone
package loop_opt_pkg;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_GLOBAL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CH0 = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_CH1 = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_COUNT0 = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_COUNT1 = 8'h14;
   // global register bits
   localparam int G_BYPASS = 0;
   localparam int G_COMMON_FAIL = 1;
   localparam int G_AND_PAIR = 2;
   localparam int G_DIR_PAIR = 3;
   // channel register bits
   localparam int C_EXT_GATE = 0;
   localparam int C_GREEN_COMP = 1;
   localparam int C_SHOW_COUNT = 2;
   localparam int C_DISCONNECT = 3;
   localparam int C_DISC_SUB = 4;
   localparam int C_AUDIBLE = 5;
   localparam int C_CLEAR = 6;
   localparam int C_LOOP_LSB = 8;
   localparam int C_EXT_LSB = 16;
   localparam logic [2:0] LOOP_MIN = 3'h1;
   localparam logic [2:0] LOOP_MAX = 3'h5;
   localparam logic [2:0] LOOP_RESET = 3'h1;
   localparam logic [7:0] EXT_RESET = 8'h00;
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_PERIOD_NS = 100_000_000;
   localparam int TICK_PER_S = 1_000_000_000 / TICK_PERIOD_NS;
   localparam int DESENS_S = 15;
   localparam int AUD_TIMEOUT_MIN = 15;
   localparam int ALT_S = 1;
   localparam int DESENS_TICKS = DESENS_S * TICK_PER_S;
   localparam int AUD_TICKS = AUD_TIMEOUT_MIN * 60 * TICK_PER_S;
   localparam int ALT_TICKS = ALT_S * TICK_PER_S;
   localparam int COUNT_W = 16;
   localparam int LOW_LIMIT = 999;
   localparam int DIGIT_SPLIT = 1000;
endpackage

/* hdl/loop_options.sv */
// per-channel and paired-channel option logic of a two-channel loop detector
// assumes occupancy and fail inputs already synchronous to clk; phase green comes raw
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/100ps
module loop_options
   import loop_opt_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // detection side
   input wire logic [1:0] occupied,
   input wire logic [1:0] loop_fail,
   input wire logic [1:0] phase_green_n,
   // controller and panel side
   output logic [1:0] call,
   output logic [1:0] fail_out,
   output logic [1:0] pending,
   output logic buzzer,
   output logic filter_bypass,
   output logic detector_reset,
   output logic [1:0] desens_step,
   output logic [1:0] show_count,
   output logic [1:0] disp_upper,
   output logic [1:0][9:0] disp_value,
   output logic [1:0][2:0] loop_config
);

   localparam int TW = $clog2(TICK_CYCLES + 1);

   logic common_fail, and_pair, dir_pair;
   logic [1:0] ext_gate, green_comp, disconnect, disc_sub, clear_bit;
   logic [1:0][7:0] ext_time;
   logic aud_on, aud_ch;
   logic [13:0] aud_cnt;
   logic [TW-1:0] tick_cnt;
   logic tick;
   logic [3:0] alt_cnt;
   logic alt_phase;
   logic srst;
   logic [1:0] pg_meta, pg_sync, green;
   logic [1:0] det_q, base_call, first_dir, disc_lat;
   logic [1:0][7:0] ext_cnt;
   logic [1:0][COUNT_W-1:0] vcount;
   logic armed, arm_ch, second_seen;
   logic [1:0] next_call, next_pending;
   logic wr_glob;

   assign srst = !rst_n || detector_reset;
   assign wr_glob = wr && addr == OFF_GLOBAL;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // 0.1 s tick used by every timer
   always_ff @(posedge clk) begin
      if (!rst_n || tick_cnt == TW'(TICK_CYCLES - 1)) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      tick <= rst_n && tick_cnt == TW'(TICK_CYCLES - 1);
   end

   // display alternation phase
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         alt_cnt <= '0;
         alt_phase <= 1'b0;
      end else if (tick) begin
         if (alt_cnt == 4'(ALT_TICKS - 1)) begin
            alt_cnt <= '0;
            alt_phase <= !alt_phase;
         end else begin
            alt_cnt <= alt_cnt + 1'b1;
         end
      end
   end

   // global settings; a changed bypass value pulses the detector reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         filter_bypass <= 1'b0;
         common_fail <= 1'b0;
         and_pair <= 1'b0;
         dir_pair <= 1'b0;
         detector_reset <= 1'b0;
      end else begin
         detector_reset <= wr_glob && wdata[G_BYPASS] != filter_bypass;
         if (wr_glob) begin
            filter_bypass <= wdata[G_BYPASS];
            common_fail <= wdata[G_COMMON_FAIL];
            and_pair <= wdata[G_AND_PAIR];
            dir_pair <= wdata[G_DIR_PAIR];
         end
      end
   end

   a_bypass_reset: assert property (wr_glob && wdata[G_BYPASS] != filter_bypass |=> detector_reset)
      else $error("bypass change gave no detector reset");

   // audible signal: one channel at a time, self-expiring; kept over a detector reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aud_on <= 1'b0;
         aud_ch <= 1'b0;
         aud_cnt <= '0;
      end else if (wr && (addr == OFF_CH0 || addr == OFF_CH1)) begin
         if (wdata[C_AUDIBLE]) begin
            aud_on <= 1'b1;
            aud_ch <= addr == OFF_CH1;
            aud_cnt <= '0;
         end else if (aud_ch == (addr == OFF_CH1)) begin
            aud_on <= 1'b0;
         end
      end else if (aud_on && tick) begin
         if (aud_cnt == 14'(AUD_TICKS - 1)) begin
            aud_on <= 1'b0;
         end
         aud_cnt <= aud_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      buzzer <= rst_n && aud_on && occupied[aud_ch];
   end

   a_aud_limit: assert property (aud_on |-> aud_cnt < AUD_TICKS)
      else $error("audible stayed on past its timeout");
   a_buzzer_follow: assert property (aud_on && occupied[aud_ch] ##1 aud_on |-> buzzer)
      else $error("buzzer silent while selected zone occupied");

   // fail reporting
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fail_out <= '0;
      end else begin
         fail_out <= loop_fail | {2{common_fail && |loop_fail}};
      end
   end

   a_common_fail: assert property (common_fail && |loop_fail |=> fail_out == 2'b11)
      else $error("shared fail did not drive both outputs");

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_ch
         localparam logic [ADDR_W-1:0] MY_OFF = i ? OFF_CH1 : OFF_CH0;
         logic wr_me, leave, enter, disc_mode, ext_ok, clr_q, comp_run;
         logic [7:0] comp_cnt;
         logic [COUNT_W-1:0] hi_part, lo_part;

         assign wr_me = wr && addr == MY_OFF;
         assign leave = det_q[i] && !occupied[i];
         assign enter = occupied[i] && !det_q[i];
         assign disc_mode = disconnect[i] && green[i];
         // the first channel of a directional pair never extends
         assign ext_ok = (!ext_gate[i] || green[i]) && !(disc_mode && disc_sub[i]) && !first_dir[i];
         assign base_call[i] = !disc_lat[i] && (occupied[i] ||
            (ext_ok && (ext_cnt[i] != 8'h00 || (leave && ext_time[i] != 8'h00))));
         assign hi_part = vcount[i] / COUNT_W'(DIGIT_SPLIT);
         assign lo_part = vcount[i] % COUNT_W'(DIGIT_SPLIT);
         assign comp_run = green_comp[i] && green[i] && comp_cnt < 8'(DESENS_TICKS) && (comp_cnt != 8'h00 || call[i]);

         // phase green: two-stage synchroniser, active low
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               pg_meta[i] <= 1'b1;
               pg_sync[i] <= 1'b1;
            end else begin
               pg_meta[i] <= phase_green_n[i];
               pg_sync[i] <= pg_meta[i];
            end
         end
         assign green[i] = !pg_sync[i];

         // channel settings; clear always reads back as off and drops once viewed
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               ext_gate[i] <= 1'b0;
               green_comp[i] <= 1'b0;
               show_count[i] <= 1'b0;
               disconnect[i] <= 1'b0;
               disc_sub[i] <= 1'b0;
               clear_bit[i] <= 1'b0;
               loop_config[i] <= LOOP_RESET;
               ext_time[i] <= EXT_RESET;
            end else if (wr_me) begin
               ext_gate[i] <= wdata[C_EXT_GATE];
               green_comp[i] <= wdata[C_GREEN_COMP];
               show_count[i] <= wdata[C_SHOW_COUNT];
               disconnect[i] <= wdata[C_DISCONNECT];
               disc_sub[i] <= wdata[C_DISC_SUB];
               clear_bit[i] <= wdata[C_CLEAR];
               ext_time[i] <= wdata[C_EXT_LSB +: 8];
               if (wdata[C_LOOP_LSB +: 3] >= LOOP_MIN && wdata[C_LOOP_LSB +: 3] <= LOOP_MAX) begin
                  loop_config[i] <= wdata[C_LOOP_LSB +: 3];
               end
            end else if (rd && addr == MY_OFF) begin
               clear_bit[i] <= 1'b0;
            end
         end

         always_ff @(posedge clk) begin
            if (srst) begin
               det_q[i] <= 1'b0;
               clr_q <= 1'b0;
            end else begin
               det_q[i] <= occupied[i];
               clr_q <= clear_bit[i];
            end
         end

         // extension countdown, also the disconnect timer during green
         always_ff @(posedge clk) begin
            if (srst || occupied[i]) begin
               ext_cnt[i] <= 8'h00;
            end else if (leave && (ext_ok || disc_mode)) begin
               ext_cnt[i] <= ext_time[i];
            end else if (tick && ext_cnt[i] != 8'h00) begin
               ext_cnt[i] <= ext_cnt[i] - 1'b1;
            end
         end

         always_ff @(posedge clk) begin
            if (srst || !disc_mode) begin
               disc_lat[i] <= 1'b0;
            end else if (!occupied[i] && ((tick && ext_cnt[i] == 8'h01) || (leave && ext_time[i] == 8'h00))) begin
               disc_lat[i] <= 1'b1;
            end
         end

         // counting wraps through the counter width; clear wins over a new vehicle
         always_ff @(posedge clk) begin
            if (srst || (clear_bit[i] && !clr_q)) begin
               vcount[i] <= '0;
            end else if (enter) begin
               vcount[i] <= vcount[i] + 1'b1;
            end
         end

         always_ff @(posedge clk) begin
            if (!rst_n) begin
               disp_value[i] <= '0;
               disp_upper[i] <= 1'b0;
            end else if (vcount[i] > COUNT_W'(LOW_LIMIT) && alt_phase) begin
               disp_value[i] <= hi_part[9:0];
               disp_upper[i] <= 1'b1;
            end else begin
               disp_value[i] <= lo_part[9:0];
               disp_upper[i] <= 1'b0;
            end
         end

         // green compensation: one step per tick for the 15 s window
         always_ff @(posedge clk) begin
            if (srst || !(green_comp[i] && green[i])) begin
               comp_cnt <= 8'h00;
            end else if (tick && comp_run) begin
               comp_cnt <= comp_cnt + 1'b1;
            end
         end

         always_ff @(posedge clk) begin
            desens_step[i] <= rst_n && !detector_reset && tick && comp_run;
         end

         a_count_clear: assert property (clear_bit[i] && !clr_q && !detector_reset |=> vcount[i] == '0)
            else $error("counter clear did not zero count");
         a_desens_bound: assert property (comp_cnt <= DESENS_TICKS)
            else $error("desensitisation ran past its window");

         sequence s_gated_leave;
            occupied[i] ##1 (!occupied[i] && ext_gate[i] && !green[i] && !disc_lat[i] && !dir_pair && !and_pair);
         endsequence
         a_gate_no_ext: assert property (s_gated_leave |=> !call[i])
            else $error("call extended outside phase green while gated");
         a_disc_quiet: assert property (disc_lat[i] && !dir_pair && !and_pair |=> !call[i])
            else $error("call output while disconnected");
      end
   endgenerate

   // directional pairing: first detector arms, second detector fires
   assign first_dir[0] = dir_pair && armed && !arm_ch;
   assign first_dir[1] = dir_pair && armed && arm_ch;

   always_ff @(posedge clk) begin
      if (srst || !dir_pair) begin
         armed <= 1'b0;
         arm_ch <= 1'b0;
         second_seen <= 1'b0;
      end else if (!armed) begin
         if (|occupied) begin
            armed <= 1'b1;
            arm_ch <= !occupied[0];
         end
      end else if (!second_seen) begin
         if (occupied[!arm_ch] && occupied[arm_ch]) begin
            second_seen <= 1'b1;
         end else if (!occupied[arm_ch]) begin
            armed <= 1'b0;
         end
      end else if (!base_call[!arm_ch]) begin
         armed <= 1'b0;
         second_seen <= 1'b0;
      end
   end

   always_comb begin
      next_call = base_call;
      next_pending = 2'b00;
      if (dir_pair) begin
         for (int k = 0; k < 2; k++) begin
            next_call[k] = armed && second_seen && arm_ch != k[0] && base_call[k];
            next_pending[k] = armed && arm_ch == k[0] && !second_seen && occupied[k];
         end
      end else if (and_pair) begin
         next_call = {2{base_call[0] && base_call[1]}};
         next_pending = occupied & ~{occupied[0], occupied[1]};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         call <= 2'b00;
         pending <= 2'b00;
      end else begin
         call <= next_call;
         pending <= next_pending;
      end
   end

   a_and_equal: assert property ($past(and_pair && !dir_pair && !detector_reset) |-> call[0] == call[1])
      else $error("paired calls differ under AND pairing");
   a_and_pending: assert property (and_pair && !dir_pair && !detector_reset && occupied == 2'b01 |=> pending == 2'b01)
      else $error("AND pairing pending wrong");
   a_dir_first_quiet: assert property (dir_pair && armed && !detector_reset |=> !call[$past(arm_ch)])
      else $error("directional first channel called");

   // register reads, answered in the next cycle
   always_ff @(posedge clk) begin
      if (!rst_n || !rd) begin
         rdata <= '0;
      end else begin
         case (addr)
            OFF_GLOBAL: rdata <= {28'h0, dir_pair, and_pair, common_fail, filter_bypass};
            OFF_CH0, OFF_CH1: begin
               rdata <= {8'h0, ext_time[addr == OFF_CH1], 5'h0, loop_config[addr == OFF_CH1], 1'b0,
                  1'b0, aud_on && aud_ch == (addr == OFF_CH1), disc_sub[addr == OFF_CH1],
                  disconnect[addr == OFF_CH1], show_count[addr == OFF_CH1],
                  green_comp[addr == OFF_CH1], ext_gate[addr == OFF_CH1]};
            end
            OFF_STATUS: rdata <= {22'h0, disc_lat, buzzer, 1'b0, fail_out, pending, call};
            OFF_COUNT0: rdata <= {16'h0, vcount[0]};
            OFF_COUNT1: rdata <= {16'h0, vcount[1]};
            default: rdata <= '0;
         endcase
      end
   end

endmodule

/* tb/green_ctrl.sv */
// traffic controller model giving one phase green per detector channel
// assumes the bench commands each green; outputs change on clk only
`timescale 1ns/100ps
module green_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bench command and controller outputs
   input wire logic [1:0] green_cmd,
   output logic [1:0] phase_green_n
);
   // low means green; held high in reset so no phase is granted by accident
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase_green_n <= 2'h3;
      end else begin
         phase_green_n <= ~green_cmd;
      end
   end
endmodule

/* tb/test_loop_options.sv */
// self-checking bench for the loop detector option block
// assumes green_ctrl as controller model and a shortened 0.1 s tick
`timescale 1ns/100ps
module test_loop_options
   import loop_opt_pkg::*;
;
   localparam int TICK = 4;
   localparam int LIMIT = 60000;
   logic clk, rst_n, wr, rd, buzzer, filter_bypass, detector_reset, hi, lo;
   logic [ADDR_W-1:0] addr;
   logic [31:0] wdata, rdata, rv;
   logic [1:0] occupied, loop_fail, phase_green_n, green_cmd, call, fail_out, pending;
   logic [1:0] desens_step, show_count, disp_upper;
   logic [1:0][9:0] disp_value;
   logic [1:0][2:0] loop_config;
   int err_count, num_checks, cycles, n;

   loop_options #(.TICK_CYCLES(TICK)) uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .occupied(occupied), .loop_fail(loop_fail),
      .phase_green_n(phase_green_n), .call(call), .fail_out(fail_out), .pending(pending),
      .buzzer(buzzer), .filter_bypass(filter_bypass), .detector_reset(detector_reset),
      .desens_step(desens_step), .show_count(show_count), .disp_upper(disp_upper),
      .disp_value(disp_value), .loop_config(loop_config));
   green_ctrl ctrl (.clk(clk), .rst_n(rst_n), .green_cmd(green_cmd), .phase_green_n(phase_green_n));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // a hang counts as a mismatch
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_count++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // sample 1 ns after the edge so the design's updates have landed
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [ADDR_W-1:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask
   function automatic logic [31:0] chv(input logic [7:0] bits, input logic [7:0] ext);
      return {8'h00, ext, 8'h01, bits};
   endfunction
   task automatic veh(input logic [1:0] m, input int hold);
      occupied <= m;
      cyc(hold);
      occupied <= 2'h0;
      cyc(3);
   endtask
   task automatic pulses(input int k);
      n = 0;
      repeat (k) begin
         cyc(1);
         if (desens_step[0] === 1'b1) n++;
      end
   endtask
   // long idle lets any running extension die before the next test
   task automatic done(input string s);
      occupied <= 2'h0;
      green_cmd <= 2'h0;
      loop_fail <= 2'h0;
      wr_reg(OFF_GLOBAL, 32'h0);
      wr_reg(OFF_CH0, chv(8'h00, 8'h00));
      wr_reg(OFF_CH1, chv(8'h00, 8'h00));
      cyc(20);
      $display("%s done", s);
   endtask

   task automatic t_regs();
      rd_reg(OFF_CH0);
      chk(rv, 32'h0000_0100);
      wr_reg(OFF_CH1, 32'h0000_0500);
      cyc(1);
      chk(32'(loop_config[1]), 32'h5);
      wr_reg(OFF_CH1, 32'h0000_0700);
      rd_reg(OFF_CH1);
      chk(rv, 32'h0000_0500);
      wr_reg(8'h20, 32'hffff_ffff);
      rd_reg(8'h20);
      chk(rv, 32'h0);
      done("regs");
   endtask

   task automatic t_ext();
      wr_reg(OFF_CH0, chv(8'h00, 8'h03));
      occupied <= 2'h1;
      cyc(3);
      chk(32'(call), 32'h1);
      occupied <= 2'h0;
      cyc(1);
      chk(32'(call), 32'h1);
      cyc(5);
      chk(32'(call), 32'h1);
      occupied <= 2'h1;
      cyc(2);
      occupied <= 2'h0;
      cyc(7);
      chk(32'(call), 32'h1);
      cyc(20);
      chk(32'(call), 32'h0);
      wr_reg(OFF_CH0, chv(8'h01, 8'h03));
      veh(2'h1, 3);
      chk(32'(call), 32'h0);
      green_cmd <= 2'h1;
      cyc(4);
      veh(2'h1, 3);
      chk(32'(call), 32'h1);
      done("extension");
   endtask

   task automatic t_count();
      wr_reg(OFF_CH1, chv(8'h04, 8'h00));
      for (int i = 0; i < 3; i++) veh(2'h2, 2);
      chk(32'(show_count), 32'h2);
      chk({21'h0, disp_upper[1], disp_value[1]}, 32'h3);
      for (int i = 3; i < 1000; i++) veh(2'h2, 2);
      rd_reg(OFF_COUNT1);
      chk(rv, 32'h0000_03e8);
      hi = 1'b0;
      lo = 1'b0;
      repeat (120) begin
         cyc(1);
         if (disp_upper[1] === 1'b1 && disp_value[1] === 10'h001) hi = 1'b1;
         if (disp_upper[1] === 1'b0 && disp_value[1] === 10'h000) lo = 1'b1;
      end
      chk({30'h0, hi, lo}, 32'h3);
      wr_reg(OFF_CH1, chv(8'h44, 8'h00));
      rd_reg(OFF_CH1);
      chk(rv, chv(8'h04, 8'h00));
      rd_reg(OFF_COUNT1);
      chk(rv, 32'h0);
      done("count");
   endtask

   task automatic t_bypass(input logic [31:0] g, input int exp);
      n = 0;
      wr_reg(OFF_GLOBAL, g);
      repeat (4) begin
         #1;
         if (detector_reset === 1'b1) n++;
         @(posedge clk);
      end
      chk(32'(n), 32'(exp));
      chk(32'(filter_bypass), g);
   endtask

   task automatic t_fail();
      loop_fail <= 2'h1;
      cyc(2);
      chk(32'(fail_out), 32'h1);
      wr_reg(OFF_GLOBAL, 32'h2);
      loop_fail <= 2'h2;
      cyc(2);
      chk(32'(fail_out), 32'h3);
      rd_reg(OFF_STATUS);
      chk(rv, 32'h30);
      done("fail");
   endtask

   task automatic t_pair();
      wr_reg(OFF_GLOBAL, 32'h4);
      occupied <= 2'h2;
      cyc(3);
      chk({28'h0, pending, call}, 32'h8);
      occupied <= 2'h3;
      cyc(3);
      chk(32'(call), 32'h3);
      occupied <= 2'h1;
      cyc(3);
      chk(32'(call), 32'h0);
      done("and pair");
      wr_reg(OFF_GLOBAL, 32'h8);
      wr_reg(OFF_CH0, chv(8'h00, 8'h03));
      occupied <= 2'h1;
      cyc(3);
      chk({28'h0, pending, call}, 32'h4);
      occupied <= 2'h3;
      cyc(3);
      chk(32'(call), 32'h2);
      occupied <= 2'h2;
      cyc(3);
      chk(32'(call), 32'h2);
      occupied <= 2'h0;
      cyc(3);
      chk(32'(call), 32'h0);
      done("direction");
   endtask

   task automatic t_aud();
      wr_reg(OFF_CH0, chv(8'h20, 8'h03));
      veh(2'h1, 3);
      chk(32'(buzzer), 32'h0);
      occupied <= 2'h1;
      cyc(3);
      chk(32'(buzzer), 32'h1);
      wr_reg(OFF_CH1, chv(8'h20, 8'h00));
      rd_reg(OFF_CH0);
      chk(rv, chv(8'h00, 8'h03));
      occupied <= 2'h2;
      cyc(3);
      chk(32'(buzzer), 32'h1);
      cyc(9000 * TICK - 60);
      chk(32'(buzzer), 32'h1);
      cyc(100);
      chk(32'(buzzer), 32'h0);
      done("audible");
   endtask

   task automatic t_disc();
      wr_reg(OFF_CH0, chv(8'h08, 8'h02));
      green_cmd <= 2'h1;
      veh(2'h1, 4);
      chk(32'(call), 32'h1);
      cyc(20);
      chk(32'(call), 32'h0);
      rd_reg(OFF_STATUS);
      chk(rv, 32'h100);
      occupied <= 2'h1;
      cyc(3);
      chk(32'(call), 32'h0);
      green_cmd <= 2'h0;
      cyc(5);
      chk(32'(call), 32'h1);
      // stay occupied so no disconnect can latch before the subtype run
      wr_reg(OFF_CH0, chv(8'h18, 8'h02));
      green_cmd <= 2'h1;
      cyc(20);
      chk(32'(call), 32'h1);
      veh(2'h1, 4);
      chk(32'(call), 32'h0);
      done("disconnect");
      wr_reg(OFF_CH0, chv(8'h02, 8'h00));
      occupied <= 2'h1;
      pulses(200);
      chk(32'(n), 32'h0);
      green_cmd <= 2'h1;
      pulses(800);
      chk(32'(n), 32'h96);
      done("compensation");
   endtask

   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      occupied = 2'h0;
      loop_fail = 2'h0;
      green_cmd = 2'h0;
      err_count = 0;
      num_checks = 0;
      cycles = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      cyc(2);
      t_regs();
      t_ext();
      t_count();
      veh(2'h1, 2);
      t_bypass(32'h1, 1);
      rd_reg(OFF_COUNT0);
      chk(rv, 32'h0);
      t_bypass(32'h1, 0);
      t_bypass(32'h0, 1);
      $display("bypass done");
      t_fail();
      t_pair();
      t_disc();
      t_aud();
      end_sim();
   end
endmodule
